// >>> src/backlight_consts.vh
/*
  Constants for the backlight configuration register bank: register
  addresses, field positions, reset values, bus address and save timing.
  Assumes inclusion by its bare name from the design file.
*/
`ifndef BACKLIGHT_CONSTS_VH
`define BACKLIGHT_CONSTS_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ADDR_SINK_CURRENT   8'ha1
`define ADDR_LOCKOUT        8'ha2
`define ADDR_SWITCH_BOOST_SWITCH_FREQUENCY    8'ha3
`define ADDR_EDGE_SLEW      8'ha4
`define ADDR_OC_SHUTDOWN    8'ha5
`define ADDR_NVM_CONTROL    8'hff

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SINK_CURRENT_MSB    3
`define LOCKOUT_MSB         2
`define SWITCH_BOOST_SWITCH_FREQUENCY_MSB     1
`define EDGE_SLEW_MSB       1
`define OC_ENABLE_BIT       0
`define SAVE_REQUEST_BIT    7
`define READBACK_SEL_BIT    0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_SINK_CURRENT    4'h5
`define RST_LOCKOUT         3'h3
`define RST_SWITCH_BOOST_SWITCH_FREQUENCY     2'h1
`define RST_EDGE_SLEW       2'h0
`define RST_OC_ENABLE       1'h0
`define RST_CONTROL         8'h00
`define RST_SAVE_REQ        1'h0
`define RST_READBACK_SEL    1'h0

// ----------------------------------------------------------------
// Bus address and timing
// ----------------------------------------------------------------
`define DEVICE_ADDR         7'h58
`define SAVE_TIME_MS        50
`define MCLK_KHZ            250000
`define SAVE_CYCLES_DFLT    24'hbebc20  // 50 ms of 250 MHz mclk

`endif

// >>> src/backlight_config_register_bank.v
/*
  Configuration register bank of a boost backlight driver, reached over
  a two-wire serial bus as a slave, with a non-volatile copy of every
  setting and a timed save operation.
  Assumes open-drain bus pins resolved outside; scl and sda arrive
  asynchronous to mclk, which runs much faster than the bus clock.
*/
// Summary of operation
// - Reserved bits dropped on write, read zero
// - All five configuration registers writable and readable
// - Four-bit full-scale sink current code
// - Three-bit input lockout threshold code
// - Two-bit boost switching frequency code
// - Two-bit switch edge slew code
// - One bit enables overcurrent shutdown
// - Save request copies working registers to memory
// - Save request bit clears itself when done
// - Readback select zero returns working values
// - Readback select one returns stored copy
// - Save takes 50 ms; stretch clock if addressed
// - Address 58h; write data auto-increments register
`include "backlight_consts.vh"

module backlight_config_register_bank #(
  parameter [23:0] SAVE_CYCLES = `SAVE_CYCLES_DFLT  // Save duration in mclk cycles
) (
  input  wire       mclk,
  input  wire       reset_n,
  input  wire       clkEn,
  input  wire       sclIn,
  output wire       sclOut,
  output wire       sclOe_n,
  input  wire       sdaIn,
  output wire       sdaOut,
  output wire       sdaOe_n,
  output wire [3:0] sinkCurrentCode,
  output wire [2:0] undervoltageThreshold,
  output wire [1:0] switchRateSelect,
  output wire [1:0] edgeRateSelect,
  output wire       overcurrentShutdownEnable,
  output wire       saveBusy
);

  // ----------------------------------------------------------------
  // Bus states
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'h0;  // Not addressed
  localparam [2:0] ST_ADDR  = 3'h1;  // Receiving slave address
  localparam [2:0] ST_REG   = 3'h2;  // Receiving register address
  localparam [2:0] ST_WDATA = 3'h3;  // Receiving write data
  localparam [2:0] ST_RDATA = 3'h4;  // Sending read data

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [1:0]  sclSync_reg;           // Clock pin synchroniser
  reg  [1:0]  sdaSync_reg;           // Data pin synchroniser
  reg         sclLast_reg;           // Previous synchronised clock
  reg         sdaLast_reg;           // Previous synchronised data
  reg  [2:0]  state_reg;             // Bus state
  reg  [3:0]  bitCnt_reg;            // Bit in byte, 8 = ack, 15 = pre-start
  reg  [7:0]  shift_reg;             // Received byte
  reg  [7:0]  tx_reg;                // Byte being sent
  reg  [7:0]  ptr_reg;               // Register pointer
  reg         readDir_reg;           // Transfer is a read
  reg         ackOn_reg;             // Device drives ack low
  reg         masterNack_reg;        // Master declined more data
  reg         stretch_reg;           // Holding bus clock low
  reg  [3:0]  csWork_reg;            // Working sink current code
  reg  [2:0]  uvWork_reg;            // Working lockout code
  reg  [1:0]  fqWork_reg;            // Working frequency code
  reg  [1:0]  srWork_reg;            // Working slew code
  reg         ilWork_reg;            // Working shutdown enable
  reg  [3:0]  csNvm_reg;             // Stored sink current code
  reg  [2:0]  uvNvm_reg;             // Stored lockout code
  reg  [1:0]  fqNvm_reg;             // Stored frequency code
  reg  [1:0]  srNvm_reg;             // Stored slew code
  reg         ilNvm_reg;             // Stored shutdown enable
  reg         saveReq_reg;           // Save request bit
  reg         readSel_reg;           // Readback source select
  reg         busy_reg;              // Save in progress
  reg  [23:0] saveCnt_reg;           // Save timer
  reg         loaded_reg;            // Power-up load done
  wire        scl;                   // Synchronised clock
  wire        sda;                   // Synchronised data
  wire        sclRise;               // Clock rising edge
  wire        sclFall;               // Clock falling edge
  wire        startSeen;             // Start or repeated start
  wire        stopSeen;              // Stop condition
  wire [7:0]  ctlByte;               // Control register image
  wire [7:0]  readValue;             // Byte returned for pointer
  wire        saveDone;              // Last cycle of save

  // ----------------------------------------------------------------
  // Register image decode, used for working and stored copies
  // ----------------------------------------------------------------
  function [7:0] regImage;
    input [7:0] addr;
    input [3:0] cs;
    input [2:0] uv;
    input [1:0] fq;
    input [1:0] sr;
    input       il;
    input [7:0] ctl;
    begin
      case (addr)
        `ADDR_SINK_CURRENT: regImage = {4'h0, cs};
        `ADDR_LOCKOUT:      regImage = {5'h00, uv};
        `ADDR_SWITCH_BOOST_SWITCH_FREQUENCY:  regImage = {6'h00, fq};
        `ADDR_EDGE_SLEW:    regImage = {6'h00, sr};
        `ADDR_OC_SHUTDOWN:  regImage = {7'h00, il};
        `ADDR_NVM_CONTROL:  regImage = ctl;
        default:            regImage = 8'h00;        // Unmapped reads zero
      endcase
    end
  endfunction
  // ----------------------------------------------------------------
  // Pin synchronisers and bus events
  // ----------------------------------------------------------------
  // Two flops per pin; only the second stage is used
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sclSync_reg <= 2'h3;
      sdaSync_reg <= 2'h3;
      sclLast_reg <= 1'b1;
      sdaLast_reg <= 1'b1;
    end else if (clkEn) begin
      sclSync_reg <= {sclSync_reg[0], sclIn};
      sdaSync_reg <= {sdaSync_reg[0], sdaIn};
      sclLast_reg <= sclSync_reg[1];
      sdaLast_reg <= sdaSync_reg[1];
    end
  end

  assign scl       = sclSync_reg[1];
  assign sda       = sdaSync_reg[1];
  assign sclRise   = scl & ~sclLast_reg;
  assign sclFall   = ~scl & sclLast_reg;
  assign startSeen = scl & sclLast_reg & sdaLast_reg & ~sda;
  assign stopSeen  = scl & sclLast_reg & ~sdaLast_reg & sda;
  // Read data from working or stored copy
  assign ctlByte   = {saveReq_reg, 6'h00, readSel_reg};
  assign readValue = readSel_reg ?
                     regImage(ptr_reg, csNvm_reg, uvNvm_reg, fqNvm_reg, srNvm_reg, ilNvm_reg, ctlByte) :
                     regImage(ptr_reg, csWork_reg, uvWork_reg, fqWork_reg, srWork_reg, ilWork_reg, ctlByte);
  // ----------------------------------------------------------------
  // Serial bus slave
  // ----------------------------------------------------------------
  // Bits are taken on clock rise and changed after clock fall
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg      <= ST_IDLE;
      bitCnt_reg     <= 4'hf;
      shift_reg      <= 8'h00;
      tx_reg         <= 8'h00;
      ptr_reg        <= 8'h00;
      readDir_reg    <= 1'b0;
      ackOn_reg      <= 1'b0;
      masterNack_reg <= 1'b0;
      stretch_reg    <= 1'b0;
    end else if (clkEn) begin
      if (stretch_reg && !busy_reg) begin
        stretch_reg <= 1'b0;                 // Release once save ends
      end
      if (stopSeen) begin
        state_reg <= ST_IDLE;                // Stop ends any transfer
        ackOn_reg <= 1'b0;
      end else if (startSeen) begin
        state_reg  <= ST_ADDR;               // Ignore the fall after start
        bitCnt_reg <= 4'hf;
        ackOn_reg  <= 1'b0;
      end else if (state_reg != ST_IDLE) begin
        if (sclRise) begin
          if (bitCnt_reg < 4'h8) begin
            shift_reg <= {shift_reg[6:0], sda};
          end else if (bitCnt_reg == 4'h8) begin
            masterNack_reg <= sda;           // Master ack after read byte
          end
        end
        if (sclFall) begin
          if (bitCnt_reg == 4'hf) begin
            bitCnt_reg <= 4'h0;              // First bit follows start
          end else if (bitCnt_reg == 4'h7) begin
            bitCnt_reg <= 4'h8;
            case (state_reg)
              ST_ADDR: begin
                if (shift_reg[7:1] == `DEVICE_ADDR) begin
                  readDir_reg <= shift_reg[0];
                  ackOn_reg   <= 1'b1;
                  stretch_reg <= busy_reg;   // Hold clock during save
                end else begin
                  state_reg <= ST_IDLE;      // Not for us
                end
              end
              ST_REG: begin
                ptr_reg   <= shift_reg;
                ackOn_reg <= 1'b1;
              end
              ST_WDATA: begin
                ptr_reg   <= ptr_reg + 8'h01;  // Auto-increment
                ackOn_reg <= 1'b1;
              end
              ST_RDATA: ackOn_reg <= 1'b0;   // Master drives ack
              default: begin
                state_reg <= ST_IDLE;
              end
            endcase
          end else if (bitCnt_reg == 4'h8) begin
            bitCnt_reg <= 4'h0;
            ackOn_reg  <= 1'b0;
            case (state_reg)
              ST_ADDR: begin
                if (readDir_reg) begin
                  state_reg <= ST_RDATA;
                  tx_reg    <= readValue;
                  ptr_reg   <= ptr_reg + 8'h01;
                end else begin
                  state_reg <= ST_REG;
                end
              end
              ST_REG, ST_WDATA: begin
                state_reg <= ST_WDATA;       // Data bytes follow
              end
              ST_RDATA: begin
                if (masterNack_reg) begin
                  state_reg <= ST_IDLE;      // No more data wanted
                end else begin
                  tx_reg  <= readValue;
                  ptr_reg <= ptr_reg + 8'h01;
                end
              end
              default: begin
                state_reg <= ST_IDLE;
              end
            endcase
          end else begin
            bitCnt_reg <= bitCnt_reg + 4'h1;
            if (state_reg == ST_RDATA) begin
              tx_reg <= {tx_reg[6:0], 1'b0};
            end
          end
        end
      end
    end
  end

  // Open-drain drives: enable low pulls the line low
  assign sdaOut  = 1'b0;
  assign sdaOe_n = ~(ackOn_reg | ((state_reg == ST_RDATA) && (bitCnt_reg < 4'h8) && !tx_reg[7]));
  assign sclOut  = 1'b0;
  assign sclOe_n = ~stretch_reg;
  // ----------------------------------------------------------------
  // Working registers and control
  // ----------------------------------------------------------------
  // A write lands when the eighth data bit completes
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      csWork_reg  <= `RST_SINK_CURRENT;
      uvWork_reg  <= `RST_LOCKOUT;
      fqWork_reg  <= `RST_SWITCH_BOOST_SWITCH_FREQUENCY;
      srWork_reg  <= `RST_EDGE_SLEW;
      ilWork_reg  <= `RST_OC_ENABLE;
      saveReq_reg <= `RST_SAVE_REQ;
      readSel_reg <= `RST_READBACK_SEL;
      loaded_reg  <= 1'b0;
    end else if (clkEn) begin
      if (!loaded_reg) begin
        loaded_reg <= 1'b1;              // Power-up defaults from stored copy
        csWork_reg <= csNvm_reg;
        uvWork_reg <= uvNvm_reg;
        fqWork_reg <= fqNvm_reg;
        srWork_reg <= srNvm_reg;
        ilWork_reg <= ilNvm_reg;
      end else if ((state_reg == ST_WDATA) && sclFall && (bitCnt_reg == 4'h7) && !stopSeen && !startSeen) begin
        case (ptr_reg)
          `ADDR_SINK_CURRENT: csWork_reg <= shift_reg[`SINK_CURRENT_MSB:0];
          `ADDR_LOCKOUT:      uvWork_reg <= shift_reg[`LOCKOUT_MSB:0];
          `ADDR_SWITCH_BOOST_SWITCH_FREQUENCY:  fqWork_reg <= shift_reg[`SWITCH_BOOST_SWITCH_FREQUENCY_MSB:0];
          `ADDR_EDGE_SLEW:    srWork_reg <= shift_reg[`EDGE_SLEW_MSB:0];
          `ADDR_OC_SHUTDOWN:  ilWork_reg <= shift_reg[`OC_ENABLE_BIT];
          `ADDR_NVM_CONTROL: begin
            readSel_reg <= shift_reg[`READBACK_SEL_BIT];
            if (!busy_reg) begin
              saveReq_reg <= shift_reg[`SAVE_REQUEST_BIT];
            end
          end
          default: ;                     // Unmapped writes ignored
        endcase
      end
      // Writes in the last save cycle still land, except the save request bit
      if (saveDone) begin
        saveReq_reg <= 1'b0;             // Self-clear
      end
    end
  end

  // ----------------------------------------------------------------
  // Save timer and stored copy
  // ----------------------------------------------------------------
  assign saveDone = busy_reg && (saveCnt_reg == SAVE_CYCLES - 24'd1);
  // Save starts at the stop after the request, copies when timed out
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busy_reg    <= 1'b0;
      saveCnt_reg <= 24'h000000;
      csNvm_reg   <= `RST_SINK_CURRENT;
      uvNvm_reg   <= `RST_LOCKOUT;
      fqNvm_reg   <= `RST_SWITCH_BOOST_SWITCH_FREQUENCY;
      srNvm_reg   <= `RST_EDGE_SLEW;
      ilNvm_reg   <= `RST_OC_ENABLE;
    end else if (clkEn) begin
      if (saveDone) begin
        busy_reg  <= 1'b0;
        csNvm_reg <= csWork_reg;         // Copy every working register
        uvNvm_reg <= uvWork_reg;
        fqNvm_reg <= fqWork_reg;
        srNvm_reg <= srWork_reg;
        ilNvm_reg <= ilWork_reg;
      end else if (busy_reg) begin
        saveCnt_reg <= saveCnt_reg + 24'd1;
      end else if (stopSeen && saveReq_reg) begin
        busy_reg    <= 1'b1;
        saveCnt_reg <= 24'h000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs to the analog control
  // ----------------------------------------------------------------
  assign sinkCurrentCode           = csWork_reg;
  assign undervoltageThreshold     = uvWork_reg;
  assign switchRateSelect          = fqWork_reg;
  assign edgeRateSelect            = srWork_reg;
  assign overcurrentShutdownEnable = ilWork_reg;
  assign saveBusy                  = busy_reg;

endmodule

// >>> dv/backlight_config_register_bank_sva.sv
/*
  Checker for the backlight configuration register bank: pin relations.
  Assumes a bind onto the design top with the same save length.
*/
module backlight_config_register_bank_sva #(
  parameter [23:0] SAVE_CYCLES = 24'h0000c8  // Save duration in mclk cycles
) (
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic       clkEn,
  input wire logic       sclIn,
  input wire logic       sclOut,
  input wire logic       sclOe_n,
  input wire logic       sdaIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe_n,
  input wire logic [3:0] sinkCurrentCode,
  input wire logic [2:0] undervoltageThreshold,
  input wire logic [1:0] switchRateSelect,
  input wire logic [1:0] edgeRateSelect,
  input wire logic       overcurrentShutdownEnable,
  input wire logic       saveBusy
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  wire [11:0] cfgOut = {sinkCurrentCode, undervoltageThreshold, switchRateSelect, edgeRateSelect,
                        overcurrentShutdownEnable};  // All working fields
  reg  [23:0] busyCnt_reg;  // Enabled cycles spent saving
  // Count the length of each save
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busyCnt_reg <= 24'h000000;
    end else if (saveBusy && clkEn) begin
      busyCnt_reg <= busyCnt_reg + 24'h000001;
    end else if (!saveBusy) begin
      busyCnt_reg <= 24'h000000;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_saveRun; saveBusy ##1 saveBusy; endsequence
  sequence s_sclHigh; sclIn [*4]; endsequence
  property p_resetValues; $rose(reset_n) |-> cfgOut == 12'h568 && saveBusy == 1'b0; endproperty
  property p_saveFreeze; s_saveRun |-> $stable(cfgOut); endproperty
  property p_enableGate; !$stable(cfgOut) |-> $past(clkEn); endproperty
  property p_saveAfterStop; $rose(saveBusy) |-> sclIn && sdaIn; endproperty
  property p_saveLength; $fell(saveBusy) |-> busyCnt_reg + 24'h000001 >= SAVE_CYCLES &&
    busyCnt_reg <= SAVE_CYCLES + 24'h000001; endproperty
  property p_stretchOnlySaving; !sclOe_n |-> saveBusy || $past(saveBusy) || $past(saveBusy, 2); endproperty
  property p_sdaSteady; s_sclHigh |-> $stable(sdaOe_n); endproperty
  property p_openDrain; sclOut == 1'b0 && sdaOut == 1'b0; endproperty
  a_resetValues: assert property (p_resetValues) else $error("outputs not at defaults after reset");
  a_saveFreeze: assert property (p_saveFreeze) else $error("setting changed during save");
  a_enableGate: assert property (p_enableGate) else $error("setting changed with clock disabled");
  a_saveAfterStop: assert property (p_saveAfterStop) else $error("save began off a stop");
  a_saveLength: assert property (p_saveLength) else $error("save length wrong");
  a_stretchOnlySaving: assert property (p_stretchOnlySaving) else $error("clock held low while idle");
  a_sdaSteady: assert property (p_sdaSteady) else $error("data pin moved while clock high");
  a_openDrain: assert property (p_openDrain) else $error("pin driven high");
endmodule

// >>> dv/i2c_host_model.sv
/*
  Bus master model on the two-wire bus: start, stop, bytes, acks.
  Assumes pull-ups on both lines; a released line reads high.
*/
module i2c_host_model (
  input  wire logic mclk,
  output logic      sclRel,
  output logic      sdaRel,
  input  wire logic sclLine,
  input  wire logic sdaLine
);
  timeunit 1ns;
  timeprecision 1ps;
  int   halfCycles = 10;  // Cycles per clock phase
  logic hung = 1'b0;      // Clock never came back high
  initial begin
    sclRel = 1'b1;
    sdaRel = 1'b1;
  end
  task automatic pause();
    repeat (halfCycles) @(posedge mclk);
  endtask
  // Release the clock and wait out a stretch of up to 1000 cycles
  task automatic sclUp();
    int n;
    sclRel <= 1'b1;
    @(posedge mclk);
    for (n = 0; n < 1000 && !sclLine; n++) begin
      @(posedge mclk);
    end
    if (!sclLine) begin
      hung = 1'b1;
    end
  endtask
  // Clock falls, then one cycle of hold before data moves
  task automatic sclDown();
    sclRel <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic bitOut(input logic b);
    sdaRel <= b;
    pause();
    sclUp();
    pause();
    sclDown();
  endtask
  task automatic bitIn(output logic b);
    sdaRel <= 1'b1;
    pause();
    sclUp();
    b = sdaLine;
    pause();
    sclDown();
  endtask
  // Data falls while clock high
  task automatic start();
    sdaRel <= 1'b1;
    pause();
    sclUp();
    pause();
    sdaRel <= 1'b0;
    pause();
    sclDown();
  endtask
  // Data rises while clock high
  task automatic stop();
    sdaRel <= 1'b0;
    pause();
    sclUp();
    pause();
    sdaRel <= 1'b1;
    pause();
  endtask
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) bitOut(d[i]);
    bitIn(b);
    ack = !b;
  endtask
  task automatic recvByte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) bitIn(d[i]);
    bitOut(last);
  endtask
endmodule

// >>> dv/backlight_config_register_bank_bench.sv
/*
  Bench for the backlight register bank: bus tasks and scenarios.
  Assumes the host model and the checker compiled before it.
*/
module backlight_config_register_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [23:0] SAVE_LEN = 24'h000190;  // Short save, still longer than one address byte
  logic       mclk, reset_n, clkEn, ack;
  wire        sclRel, sdaRel, sclOut, sclOe_n, sdaOut, sdaOe_n, saveBusy, ocEn;
  wire  [3:0] sinkCode;
  wire  [2:0] uvCode;
  wire  [1:0] freqCode, slewCode;
  wire        sclLine = sclRel & (sclOe_n | sclOut);  // Open-drain with pull-up
  wire        sdaLine = sdaRel & (sdaOe_n | sdaOut);
  wire [11:0] cfg = {sinkCode, uvCode, freqCode, slewCode, ocEn};
  int         error_cnt = 0;
  int         samples_checked = 0;
  logic [7:0] wb [0:4];  // Burst write bytes
  logic [7:0] rb [0:4];  // Burst read bytes
  longint     t0;
  logic       stretchSeen = 1'b0;  // Device has held the bus clock low
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  backlight_config_register_bank #(.SAVE_CYCLES(SAVE_LEN)) i_backlight_config_register_bank (
    .mclk(mclk), .reset_n(reset_n), .clkEn(clkEn), .sclIn(sclLine), .sclOut(sclOut), .sclOe_n(sclOe_n),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .sinkCurrentCode(sinkCode),
    .undervoltageThreshold(uvCode), .switchRateSelect(freqCode), .edgeRateSelect(slewCode),
    .overcurrentShutdownEnable(ocEn), .saveBusy(saveBusy));
  i2c_host_model i_i2c_host_model (.mclk(mclk), .sclRel(sclRel), .sdaRel(sdaRel), .sclLine(sclLine),
    .sdaLine(sdaLine));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic addrPhase(input logic [7:0] a);
    i_i2c_host_model.start();
    i_i2c_host_model.sendByte(8'hb0, ack);
    chk("slave ack", 12'h001, {11'h000, ack});
    i_i2c_host_model.sendByte(a, ack);
    chk("pointer ack", 12'h001, {11'h000, ack});
  endtask
  task automatic wrBurst(input logic [7:0] a, input int n);
    addrPhase(a);
    for (int k = 0; k < n; k++) begin
      i_i2c_host_model.sendByte(wb[k], ack);
      chk("data ack", 12'h001, {11'h000, ack});
    end
    i_i2c_host_model.stop();
  endtask
  task automatic wr1(input logic [7:0] a, input logic [7:0] d);
    wb[0] = d;
    wrBurst(a, 1);
  endtask
  // Read n bytes from a upward; expected bytes packed from the top
  task automatic rdChk(input logic [7:0] a, input int n, input logic [39:0] exp);
    addrPhase(a);
    i_i2c_host_model.start();
    i_i2c_host_model.sendByte(8'hb1, ack);
    chk("read ack", 12'h001, {11'h000, ack});
    for (int k = 0; k < n; k++) i_i2c_host_model.recvByte(rb[k], k == n - 1);
    i_i2c_host_model.stop();
    for (int k = 0; k < n; k++) chk("read data", {4'h0, exp[39 - 8 * k -: 8]}, {4'h0, rb[k]});
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Clock stretch that never ends
  always @(posedge i_i2c_host_model.hung) begin
    error_cnt++;
    complete_run();
  end
  // Note any cycle with the bus clock held by the device
  always @(posedge mclk) begin
    if (!sclOe_n) begin
      stretchSeen <= 1'b1;
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    clkEn = 1'b1;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("defaults", 12'h568, cfg);
    rdChk(8'ha1, 5, 40'h0503010000);
    rdChk(8'h10, 1, 40'h0000000000);
    i_i2c_host_model.start();
    i_i2c_host_model.sendByte(8'h74, ack);
    chk("foreign address", 12'h000, {11'h000, ack});
    i_i2c_host_model.stop();
    clkEn <= 1'b0;
    repeat (8) @(posedge mclk);
    clkEn <= 1'b1;
    i_i2c_host_model.halfCycles = 6;
    for (int i = 0; i < 16; i++) begin
      for (int k = 0; k < 5; k++) wb[k] = {i[3:0], i[3:0]};
      wrBurst(8'ha1, 5);
      chk("fields", {i[3:0], i[2:0], i[1:0], i[1:0], i[0]}, cfg);
    end
    i_i2c_host_model.halfCycles = 10;
    rdChk(8'ha1, 5, 40'h0f07030301);
    wr1(8'hff, 8'h01);
    rdChk(8'ha1, 5, 40'h0503010000);
    wr1(8'hff, 8'h7e);
    rdChk(8'hff, 1, 40'h0000000000);
    // Enable high and dimming low are pins outside this block
    wr1(8'hff, 8'h80);
    repeat (8) @(posedge mclk);
    chk("busy", 12'h001, {11'h000, saveBusy});
    t0 = $time;
    // Address byte ends well before the save; only a stretch delays the ack
    i_i2c_host_model.start();
    i_i2c_host_model.sendByte(8'hb0, ack);
    chk("ack after save", 12'h001, {11'h000, ack});
    chk("stretched", 12'h001, {11'h000, ($time - t0) >= 4 * (SAVE_LEN - 24'h000020)});
    chk("stretch seen", 12'h001, {11'h000, stretchSeen});
    chk("idle", 12'h000, {11'h000, saveBusy});
    i_i2c_host_model.stop();
    rdChk(8'hff, 1, 40'h0000000000);
    wr1(8'hff, 8'h01);
    rdChk(8'ha1, 5, 40'h0f07030301);
    wr1(8'hff, 8'h00);
    complete_run();
  end
endmodule

bind backlight_config_register_bank backlight_config_register_bank_sva #(.SAVE_CYCLES(SAVE_CYCLES))
  i_backlight_config_register_bank_sva (.mclk(mclk), .reset_n(reset_n), .clkEn(clkEn), .sclIn(sclIn),
  .sclOut(sclOut), .sclOe_n(sclOe_n), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
  .sinkCurrentCode(sinkCurrentCode), .undervoltageThreshold(undervoltageThreshold),
  .switchRateSelect(switchRateSelect), .edgeRateSelect(edgeRateSelect),
  .overcurrentShutdownEnable(overcurrentShutdownEnable), .saveBusy(saveBusy));
